// ### verilog/pin_select_pkg.sv
// Constants, field layouts and types of the memory-select pin assignment block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package pin_select_pkg;
    // Register byte offsets on the register bus
    localparam logic [11:0] OFFSET_LATCH = 12'h000;
    localparam logic [11:0] OFFSET_SELECT_LOW = 12'h004;
    localparam logic [11:0] OFFSET_SELECT_HIGH = 12'h008;
    // Writable bit masks, the forced-one bit of the low register and the latch reset value
    localparam logic [15:0] MASK_LATCH = 16'h007F;
    localparam logic [15:0] MASK_SELECT_LOW = 16'h3FFD;
    localparam logic [15:0] MASK_SELECT_HIGH = 16'h03FF;
    localparam logic [15:0] FORCED_ONE_LOW = 16'h0002;
    localparam logic [15:0] RESET_LATCH = 16'h007F;
    // Pin counts and field geometry
    localparam int PIN_COUNT = 12;
    localparam int LOW_FIELDS = 7;
    localparam int HIGH_FIELDS = 5;
    localparam int FIELD_WIDTH = 2;
    localparam int STRAP_HIGH_BASE = 3;
    // Pin function encodings
    localparam logic [1:0] FIELD_DISCRETE = 2'h0;
    localparam logic [1:0] FIELD_ALTERNATE = 2'h1;
    localparam logic [1:0] FIELD_SELECT_8 = 2'h2;
    localparam logic [1:0] FIELD_SELECT_16 = 2'h3;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {pin_discrete, pin_alternate, pin_select_8, pin_select_16} pin_role_t;

    // Role of a pin from its field
    function automatic pin_role_t decode_role(input logic [1:0] field);
        case (field)
            FIELD_DISCRETE: decode_role = pin_discrete;
            FIELD_ALTERNATE: decode_role = pin_alternate;
            FIELD_SELECT_8: decode_role = pin_select_8;
            default: decode_role = pin_select_16;
        endcase
    endfunction
endpackage

// ### verilog/pin_config_if.sv
// Interface carrying the configuration registers to the pin multiplexer
`timescale 1ns/10ps
interface pin_config_if;
    logic [15:0] latch;
    logic [15:0] select_low;
    logic [15:0] select_high;
    modport source (output latch, output select_low, output select_high);
    modport sink (input latch, input select_low, input select_high);
endinterface

// ### verilog/reset_strap_decode.sv
// Reset values of the pin function registers derived from the data bus level
`timescale 1ns/10ps
module reset_strap_decode
    import pin_select_pkg::*;
(
    input wire logic [7:0] data_bus_in,
    output logic [15:0] low_reset,
    output logic [15:0] high_reset
);
    // ----------------------------------------------------------------
    // Low register: boot field keeps bit 1 set, data bit 0 below it
    // ----------------------------------------------------------------
    assign low_reset = {2'h0, data_bus_in[2], 1'b1, data_bus_in[2], 1'b1, data_bus_in[2], 1'b1,
                        data_bus_in[1], 1'b1, data_bus_in[1], 1'b1, data_bus_in[1], 1'b1,
                        1'b1, data_bus_in[0]};

    // ----------------------------------------------------------------
    // High register: a zero on the bus turns that pin and all below into address lines
    // ----------------------------------------------------------------
    assign high_reset[15:2 * HIGH_FIELDS] = '0;
    genvar f;
    generate
        for (f = 0; f < HIGH_FIELDS; f++) begin : g_high
            assign high_reset[2 * f + 1] = &data_bus_in[7:STRAP_HIGH_BASE + f];
            assign high_reset[2 * f] = 1'b1;
        end
    endgenerate
endmodule // reset_strap_decode

// ### verilog/pin_function_mux.sv
// Per-pin selection between memory select, alternate function and discrete output (latch bit, or E clock on pin 11)
`timescale 1ns/10ps
module pin_function_mux
    import pin_select_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    pin_config_if.sink cfg,
    input wire logic [PIN_COUNT-1:0] select_strobe_n,
    input wire logic [PIN_COUNT-1:0] alternate_out,
    input wire logic [PIN_COUNT-1:0] alternate_oe,
    input wire logic e_phase_clock,
    input wire logic bus_request_pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe,
    output logic [PIN_COUNT-1:0] port_is_16,
    output logic bus_request_pin
);
    logic [2*PIN_COUNT-1:0] fields;
    logic [PIN_COUNT-1:0] has_discrete;
    logic [PIN_COUNT-1:0] discrete_level;
    logic [PIN_COUNT-1:0] next_out;
    logic [PIN_COUNT-1:0] next_oe;
    logic [PIN_COUNT-1:0] next_wide;

    // ----------------------------------------------------------------
    // Pin order: 0 boot, 1..6 selects 0..5, 7..11 selects 6..10
    // ----------------------------------------------------------------
    assign fields = {cfg.select_high[2*HIGH_FIELDS-1:0], cfg.select_low[2*LOW_FIELDS-1:0]};
    // Selects 0..2 have no discrete output; the boot pin never reaches it
    assign has_discrete = 12'hF80 | 12'h070;
    assign discrete_level = {e_phase_clock, cfg.latch[6:3], cfg.latch[2:0], 3'h0, 1'b0};

    genvar p;
    generate
        for (p = 0; p < PIN_COUNT; p++) begin : g_pin
            logic [1:0] field;
            pin_role_t role;
            assign field = fields[2*p +: 2];
            // The boot pin forces bit 1 high, so only the two select roles remain
            assign role = (p == 0) ? decode_role({1'b1, field[0]}) : decode_role(field);
            assign next_out[p] = (role == pin_discrete) ? discrete_level[p] :
                                 (role == pin_alternate) ? alternate_out[p] : select_strobe_n[p];
            // Request pin is an input in its alternate role, so never drive it there
            assign next_oe[p] = (role == pin_discrete) ? has_discrete[p] :
                                (role == pin_alternate) ? (alternate_oe[p] && p != 1) : 1'b1;
            assign next_wide[p] = (role == pin_select_16);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Output flops; all pins idle undriven during reset
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= '1;
            pin_oe <= '0;
            port_is_16 <= '0;
            bus_request_pin <= 1'b1;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            port_is_16 <= next_wide;
            // Released request reads inactive high when the pin has another role
            bus_request_pin <= (fields[3:2] == FIELD_ALTERNATE) ? bus_request_pin_in : 1'b1;
        end
    end
endmodule // pin_function_mux

// ### verilog/chip_select_pin_assignment.sv
// Top of the memory-select pin assignment block with its AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module chip_select_pin_assignment
    import pin_select_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Data bus level held by external logic during reset
    input wire logic [7:0] data_bus_in,
    // Pin sources from the rest of the chip
    input wire logic [PIN_COUNT-1:0] select_strobe_n,
    input wire logic [PIN_COUNT-1:0] alternate_out,
    input wire logic [PIN_COUNT-1:0] alternate_oe,
    input wire logic e_phase_clock_output,
    input wire logic bus_request_pin_in,
    // Pins
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe,
    output logic [PIN_COUNT-1:0] port_is_16,
    output logic bus_request_pin
);
    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    generate
        if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin : g_bad_width
            // Refused while the design is built, before any clock runs
            $error("ADDR_WIDTH must lie between 4 and 32");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [15:0] discrete_output_latch;
    logic [15:0] pin_function_select_low;
    logic [15:0] pin_function_select_high;
    logic [15:0] low_reset;
    logic [15:0] high_reset;

    // Held write address and data; either may arrive first
    logic aw_held;
    logic w_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    pin_config_if cfg_bus ();

    reset_strap_decode u_strap (
        .data_bus_in(data_bus_in),
        .low_reset(low_reset),
        .high_reset(high_reset)
    );

    pin_function_mux u_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg_bus.sink),
        .select_strobe_n(select_strobe_n),
        .alternate_out(alternate_out),
        .alternate_oe(alternate_oe),
        .e_phase_clock(e_phase_clock_output),
        .bus_request_pin_in(bus_request_pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .port_is_16(port_is_16),
        .bus_request_pin(bus_request_pin)
    );

    assign cfg_bus.latch = discrete_output_latch;
    assign cfg_bus.select_low = pin_function_select_low;
    assign cfg_bus.select_high = pin_function_select_high;

    // ----------------------------------------------------------------
    // Write address decode
    // ----------------------------------------------------------------
    logic [11:0] wr_offset;
    logic wr_hit_latch;
    logic wr_hit_low;
    logic wr_hit_high;
    logic wr_mapped;
    logic wr_fire;
    logic [15:0] byte_mask;
    logic [15:0] wr_value;

    // Only address bits 11..2 decode; bits 1..0 and the upper ones alias
    assign wr_offset = 12'(aw_addr) & 12'hFFC;
    assign wr_hit_latch = (wr_offset == OFFSET_LATCH);
    assign wr_hit_low = (wr_offset == OFFSET_SELECT_LOW);
    assign wr_hit_high = (wr_offset == OFFSET_SELECT_HIGH);
    assign wr_mapped = wr_hit_latch | wr_hit_low | wr_hit_high;
    // The write happens once both halves are held and no answer is pending
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign byte_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wr_value = w_data[15:0];

    // Merge a write into a register while keeping its fixed bits
    function automatic logic [15:0] merge_write(input logic [15:0] old_value, input logic [15:0] wmask,
                                                input logic [15:0] forced_one);
        merge_write = ((old_value & ~(byte_mask & wmask)) | (wr_value & byte_mask & wmask)) | forced_one;
    endfunction

    // ----------------------------------------------------------------
    // Write channel handshake
    // ----------------------------------------------------------------
    // Ready drops after a take and rises again when the response is accepted,
    // which keeps at most one write in flight without any queue.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            aw_held <= 1'b0;
        end
    end

    // Write data is taken on its own channel in the same manner
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
            w_held <= 1'b0;
        end
    end

    // Response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Reset is synchronous, so the data bus is sampled on every edge during reset
    // and the last level before release remains as the configuration.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_function_select_low <= low_reset;
            pin_function_select_high <= high_reset;
        end else if (wr_fire && wr_hit_low) begin
            pin_function_select_low <= merge_write(pin_function_select_low, MASK_SELECT_LOW, FORCED_ONE_LOW);
        end else if (wr_fire && wr_hit_high) begin
            pin_function_select_high <= merge_write(pin_function_select_high, MASK_SELECT_HIGH, 16'h0000);
        end
    end

    // Discrete latch; only seven bits exist
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            discrete_output_latch <= RESET_LATCH;
        end else if (wr_fire && wr_hit_latch) begin
            discrete_output_latch <= merge_write(discrete_output_latch, MASK_LATCH, 16'h0000);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [11:0] rd_offset;
    logic rd_hit_latch;
    logic rd_hit_low;
    logic rd_hit_high;
    logic rd_mapped;
    logic [15:0] rd_value;

    assign rd_offset = 12'(s_axi_araddr) & 12'hFFC;
    assign rd_hit_latch = (rd_offset == OFFSET_LATCH);
    assign rd_hit_low = (rd_offset == OFFSET_SELECT_LOW);
    assign rd_hit_high = (rd_offset == OFFSET_SELECT_HIGH);
    assign rd_mapped = rd_hit_latch | rd_hit_low | rd_hit_high;
    // Masks keep unused bits at their fixed levels on the way out as well
    assign rd_value = rd_hit_latch ? (discrete_output_latch & MASK_LATCH) :
                      rd_hit_low ? ((pin_function_select_low & MASK_SELECT_LOW) | FORCED_ONE_LOW) :
                      rd_hit_high ? (pin_function_select_high & MASK_SELECT_HIGH) : 16'h0000;

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_value};
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // chip_select_pin_assignment

// ### dv/pin_select_sva.sv
// Port checker of the memory-select pin assignment block
`timescale 1ns/10ps
module pin_select_sva
    import pin_select_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic [7:0] data_bus_in,
    input wire logic [PIN_COUNT-1:0] select_strobe_n,
    input wire logic bus_request_pin_in,
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe,
    input wire logic [PIN_COUNT-1:0] port_is_16,
    input wire logic bus_request_pin
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [11:0] rd_addr;
    logic [7:0] strap;
    logic [4:0] chain;
    // Strap is the bus level at the last edge in reset; the read address is kept for its answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap <= data_bus_in;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            // Same alignment and aliasing as the read decoder, for any address width
            rd_addr <= 12'(s_axi_araddr) & 12'hFFC;
        end
    end
    // A high select stays a memory select only while every data bit above it read one
    assign chain = {strap[7], &strap[7:6], &strap[7:5], &strap[7:4], &strap[7:3]};
    property p_is16;
        (port_is_16 & ~pin_oe) == 0 && ((pin_out ^ $past(select_strobe_n)) & port_is_16) == 0;
    endproperty
    a_is16: assert property (p_is16) else $error("16-bit select pin not driven by its strobe");
    property p_boot;
        $past(aresetn) |-> pin_oe[0] && pin_out[0] == $past(select_strobe_n[0]);
    endproperty
    a_boot: assert property (p_boot) else $error("boot pin is not a memory select");
    property p_req;
        !bus_request_pin |-> !$past(bus_request_pin_in) && !pin_oe[1];
    endproperty
    a_req: assert property (p_req) else $error("request input not taken from an undriven pin");
    property p_rd_latch;
        s_axi_rvalid && rd_addr == OFFSET_LATCH |-> s_axi_rdata[31:7] == 0;
    endproperty
    a_rd_latch: assert property (p_rd_latch) else $error("latch top bits read nonzero");
    property p_rd_top;
        s_axi_rvalid && rd_addr == OFFSET_SELECT_LOW |-> s_axi_rdata[31:14] == 0;
    endproperty
    a_rd_top: assert property (p_rd_top) else $error("low select top bits read nonzero");
    property p_rd_fixed;
        s_axi_rvalid && rd_addr == OFFSET_SELECT_LOW |-> s_axi_rdata[1];
    endproperty
    a_rd_fixed: assert property (p_rd_fixed) else $error("low select bit 1 read zero");
    property p_rd_high;
        s_axi_rvalid && rd_addr == OFFSET_SELECT_HIGH |=> $past(s_axi_rdata[31:10]) == 0;
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("high select top bits read nonzero");
    property p_rst_high;
        $past(aresetn) && !$past(aresetn, 2) |-> port_is_16[11:7] == chain;
    endproperty
    a_rst_high: assert property (p_rst_high) else $error("high selects wrong after reset");
    property p_rst_low;
        $past(aresetn) && !$past(aresetn, 2) |-> port_is_16[6:0] == {{3{strap[2]}}, {3{strap[1]}}, strap[0]};
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("low selects wrong after reset");
endmodule // pin_select_sva

bind chip_select_pin_assignment pin_select_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.aclk, .aresetn, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .data_bus_in, .select_strobe_n,
    .bus_request_pin_in, .pin_out, .pin_oe, .port_is_16, .bus_request_pin);

// ### dv/memory_side_model.sv
// Model of the external logic on the data bus and the request pin
`timescale 1ns/10ps
module memory_side_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] strap,
    input wire logic req_level,
    output logic [7:0] data_bus_in,
    output logic bus_request_pin_in
);
    logic [7:0] last;
    // Strap held during reset; a released bus toggles so stale levels never look valid
    always_ff @(posedge aclk) begin
        last <= data_bus_in;
    end
    assign data_bus_in = aresetn ? ~last : strap;
    assign bus_request_pin_in = req_level;
endmodule // memory_side_model

// ### dv/chip_select_pin_assignment_bench.sv
// Self-checking bench of the memory-select pin assignment block
`timescale 1ns/10ps
module chip_select_pin_assignment_bench;
    import pin_select_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, e_phase_clock_output, req_level;
    logic bus_request_pin_in, bus_request_pin;
    logic [11:0] s_axi_awaddr, s_axi_araddr, select_strobe_n, alternate_out, alternate_oe, pin_out, pin_oe, port_is_16;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] strap, data_bus_in;
    logic [31:0] seed = 32'hAE41;
    int num_errors = 0;
    int tests_run = 0;
    logic [15:0] m_reg[3];
    logic [11:0] offs[4] = '{OFFSET_LATCH, OFFSET_SELECT_LOW, OFFSET_SELECT_HIGH, 12'h00C};
    logic [15:0] masks[3] = '{MASK_LATCH, MASK_SELECT_LOW, MASK_SELECT_HIGH};
    logic [7:0] straps[6] = '{8'hFF, 8'hF7, 8'hEE, 8'hD9, 8'hB2, 8'h64};
    chip_select_pin_assignment u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .data_bus_in, .select_strobe_n, .alternate_out, .alternate_oe, .e_phase_clock_output,
        .bus_request_pin_in, .pin_out, .pin_oe, .port_is_16, .bus_request_pin);
    memory_side_model u_far (.aclk, .aresetn, .strap, .req_level, .data_bus_in, .bus_request_pin_in);
    // Clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check_bus(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_pin(input string what, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] pin %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Bounded wait: a missing answer ends the run instead of hanging it
    task automatic guard(inout int n);
        n++;
        if (n > 50) begin
            num_errors++;
            $display("[FAIL] handshake expected answer seen none");
            stop_test();
        end
    endtask
    // Ready is looked at on the falling edge so the taking edge is known without races
    task automatic axi_write(input int idx, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic ta, tw, tb;
        logic [15:0] bm;
        n = 0;
        tb = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= offs[idx];
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            if (tb) check_bus("write response", {30'h0, idx < 3 ? RESP_OKAY : RESP_SLVERR}, {30'h0, s_axi_bresp});
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
            guard(n);
        end
        if (idx < 3) begin
            bm = {{8{s[1]}}, {8{s[0]}}} & masks[idx];
            m_reg[idx] = (m_reg[idx] & ~bm) | (d[15:0] & bm) | (idx == 1 ? 16'h0002 : 16'h0000);
        end
    endtask
    task automatic axi_read(input int idx);
        int n;
        logic ta, tr;
        n = 0;
        tr = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= offs[idx];
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            if (tr) check_bus("read data", idx < 3 ? {16'h0, m_reg[idx]} : 32'h0, s_axi_rdata);
            if (tr) check_bus("read response", {30'h0, idx < 3 ? RESP_OKAY : RESP_SLVERR}, {30'h0, s_axi_rresp});
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
            guard(n);
        end
    endtask
    task automatic do_reset(input logic [7:0] s);
        int i, j;
        logic a;
        @(posedge aclk);
        strap <= s;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        m_reg[0] = 16'h007F;
        m_reg[1] = {15'h0, s[0]} | 16'h0002;
        m_reg[2] = 16'h0000;
        for (i = 1; i < 7; i++) begin
            m_reg[1] |= {14'h0, (i < 4 ? s[1] : s[2]), 1'b1} << (2 * i);
        end
        for (i = 0; i < 5; i++) begin
            a = 1'b1;
            for (j = 3 + i; j < 8; j++) a &= s[j];
            m_reg[2] |= {14'h0, a, 1'b1} << (2 * i);
        end
    endtask
    task automatic check_pins();
        logic [11:0] eo, ev, e16, er;
        logic [31:0] r;
        logic [1:0] f;
        int i;
        @(posedge aclk);
        r = rnd();
        select_strobe_n <= r[11:0];
        alternate_out <= r[23:12];
        r = rnd();
        alternate_oe <= r[11:0];
        e_phase_clock_output <= r[12];
        req_level <= r[13];
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        for (i = 0; i < 12; i++) begin
            f = i < 7 ? m_reg[1][2*i +: 2] : m_reg[2][2*(i-7) +: 2];
            e16[i] = f == FIELD_SELECT_16;
            eo[i] = f[1] || (f == FIELD_ALTERNATE ? i != 1 && alternate_oe[i] : i > 3);
            ev[i] = f[1] ? select_strobe_n[i] : f[0] ? alternate_out[i] : i == 11 ? e_phase_clock_output : m_reg[0][i-4];
        end
        // Request input reads inactive high unless select 0 is in its alternate role
        er = {11'h0, m_reg[1][3:2] == FIELD_ALTERNATE ? req_level : 1'b1};
        check_pin("enables", eo, pin_oe);
        check_pin("levels", ev & eo, pin_out & eo);
        check_pin("16-bit ports", e16, port_is_16);
        check_pin("bus request", er, {11'h0, bus_request_pin});
    endtask
    // Main sequence: reset straps, every field code on every pin but the boot pin, then random traffic
    initial begin
        int i, k;
        logic [31:0] r;
        aresetn = 1'b0;
        strap = 8'hFF;
        req_level = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, e_phase_clock_output} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, select_strobe_n, alternate_out, alternate_oe} = 60'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        for (k = 0; k < 6; k++) begin
            do_reset(straps[k]);
            for (i = 0; i < 4; i++) axi_read(i);
            check_pins();
        end
        for (k = 0; k < 4; k++) begin
            for (i = 0; i < 4; i++) axi_write(i, 32'h5555_5555 * k, 4'hF);
            for (i = 0; i < 4; i++) axi_read(i);
            check_pins();
        end
        for (k = 0; k < 24; k++) begin
            r = rnd();
            axi_write(r[1:0], rnd(), r[5:2]);
            axi_read(r[1:0]);
            check_pins();
        end
        stop_test();
    end
endmodule // chip_select_pin_assignment_bench
